// ---- pkg/range_compare_map.vh ----
// Constants for the table and range compare datapath.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef RANGE_COMPARE_MAP_VH
`define RANGE_COMPARE_MAP_VH
`define OPC_TABLE_EQUAL 12'h085
`define OPC_BLOCK_RANGE 12'h068
`define OPC_SINGLE_RANGE 12'h088
`define OPC_DOUBLE_RANGE 12'h116
`define TABLE_WORDS 6'd16
`define BLOCK_WORDS 6'd32
`define LAST_TABLE_IDX 6'd15
`define LAST_BLOCK_IDX 6'd31
`define SINGLE_WORDS 6'd3
`define DOUBLE_WORDS 6'd6
`define RESULT_RESET 16'h0000
`endif

// ---- hdl/operand_latch.v ----
// Small word store for the operand words fetched during one operation.
// Assumes one clock and an asynchronous active-low reset; read data are registered.
`timescale 1ns/1ps
module operand_latch #(
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire ref_clk,
  input wire rst_b,
  input wire writeEn,
  input wire [AW-1:0] writeAddr,
  input wire [15:0] writeData,
  input wire [AW-1:0] readAddr,
  output reg [15:0] readData
);
  reg [15:0] mem [0:DEPTH-1];

  // Writes store a word; reads return the addressed word one cycle later.
  always @(posedge ref_clk) begin
    if (writeEn) begin
      mem[writeAddr] <= writeData;
    end
  end

  // Registered read port with defined reset value.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      readData <= 16'h0000;
    end else begin
      readData <= mem[readAddr];
    end
  end
endmodule // operand_latch

// ---- hdl/table_range_compare_unit.v ----
// Comparison datapath: table equality, block range and single range compares.
// Assumes a sequencer issues operations and a data memory answers reads one cycle later.
`timescale 1ns/1ps
`include "range_compare_map.vh"
// Operation
// - Result bit n set when word equals source
// - Table compare: equal if result zero, error cleared
// - Table compare code 085, also edge-triggered form
// - Block compare reads thirty-two words from base
// - Range n limits at words 2n, 2n+1
// - Result bit set when source inside inclusive range
// - Reversed limits give zero bit, no error
// - Block compare: equal if none matched, error cleared
// - Block compare code 068, also edge-triggered form
// - Code 088 compares 16-bit value with range
// - Code 116 compares 32-bit values, high word upper
// - Greater above upper, equal inside, less below lower
// - Single range leaves other flags unchanged
// - Single range sets error when lower exceeds upper
module table_range_compare_unit #(
  parameter AW = 16
) (
  input wire ref_clk,
  input wire rst_b,
  input wire opStart,
  input wire [11:0] opCode,
  input wire opDifferentiated,
  input wire inputCondition,
  input wire [15:0] sourceWord,
  input wire [AW-1:0] baseAddr,
  input wire [AW-1:0] lowerAddr,
  input wire [AW-1:0] upperAddr,
  output reg memRead,
  output reg [AW-1:0] memAddr,
  input wire [15:0] memReadData,
  output reg resultWrite,
  output reg [15:0] resultWord,
  output reg opDone,
  output reg opBusy,
  output reg errorFlag,
  output reg equalFlag,
  output reg greaterFlag,
  output reg lessFlag,
  output reg greaterOrEqualFlag,
  output reg lessOrEqualFlag,
  output reg notEqualFlag,
  output reg negativeFlag
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_FETCH = 4'b0010;
  localparam [3:0] ST_LOAD = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg [3:0] state_reg;
  reg [11:0] opCode_reg;
  reg [15:0] source_reg;
  reg [AW-1:0] base_reg;
  reg [AW-1:0] lower_reg;
  reg [AW-1:0] upper_reg;
  reg [5:0] issue_reg;
  reg [5:0] count_reg;
  reg [5:0] total_reg;
  reg lastCond_reg;
  reg [15:0] mask_reg;
  reg [15:0] lowWord_reg;
  reg [15:0] valueHigh_reg;
  reg [31:0] upLatch_reg;
  reg [31:0] lowLatch_reg;
  wire [15:0] latchData;
  wire [31:0] valueWord;
  wire [5:0] captureIdx;
  reg pendingRead_reg;
  reg [5:0] pendingIdx_reg;

  // Range membership on unsigned values, with reversed limits giving no match.
  function inRange;
    input [31:0] val;
    input [31:0] lo;
    input [31:0] hi;
    begin
      inRange = (lo <= hi) && (val >= lo) && (val <= hi);
    end
  endfunction

  // Known operation codes.
  function validOp;
    input [11:0] code;
    begin
      validOp = (code == `OPC_TABLE_EQUAL) || (code == `OPC_BLOCK_RANGE) ||
        (code == `OPC_SINGLE_RANGE) || (code == `OPC_DOUBLE_RANGE);
    end
  endfunction

  wire condRise = inputCondition && !lastCond_reg;
  wire fireOk = inputCondition && (!opDifferentiated || condRise);
  wire accept = opStart && validOp(opCode) && fireOk && state_reg == ST_IDLE;
  wire isTable = opCode_reg == `OPC_TABLE_EQUAL;
  wire isBlock = opCode_reg == `OPC_BLOCK_RANGE;
  wire isDouble = opCode_reg == `OPC_DOUBLE_RANGE;
  assign captureIdx = pendingIdx_reg;
  // The compared value takes its low word from operand word 0 kept in the store.
  assign valueWord = {valueHigh_reg, latchData};

  // Word store for the fetched operands; word 0 stays readable until the evaluation.
  operand_latch #(.DEPTH(32), .AW(5)) u_latch (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .writeEn(pendingRead_reg),
    .writeAddr(captureIdx[4:0]),
    .writeData(memReadData),
    .readAddr(5'd0),
    .readData(latchData)
  );

  // Address of the word fetched at a given index for the current operation.
  function [AW-1:0] fetchAddr;
    input [5:0] idx;
    begin
      if (isTable || isBlock) begin
        fetchAddr = base_reg + {{(AW-6){1'b0}}, idx};
      end else if (isDouble) begin
        case (idx[2:1])
          2'd0: fetchAddr = base_reg + {{(AW-1){1'b0}}, idx[0]};
          2'd1: fetchAddr = lower_reg + {{(AW-1){1'b0}}, idx[0]};
          default: fetchAddr = upper_reg + {{(AW-1){1'b0}}, idx[0]};
        endcase
      end else begin
        case (idx[1:0])
          2'd0: fetchAddr = base_reg;
          2'd1: fetchAddr = lower_reg;
          default: fetchAddr = upper_reg;
        endcase
      end
    end
  endfunction

  // Sequencer: issue reads, collect answers a cycle later, then write back the mask (table, block) or update the flags (ranges).
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      opCode_reg <= 12'h000;
      source_reg <= 16'h0000;
      base_reg <= {AW{1'b0}};
      lower_reg <= {AW{1'b0}};
      upper_reg <= {AW{1'b0}};
      issue_reg <= 6'd0;
      count_reg <= 6'd0;
      total_reg <= 6'd0;
      lastCond_reg <= 1'b0;
      mask_reg <= `RESULT_RESET;
      lowWord_reg <= 16'h0000;
      valueHigh_reg <= 16'h0000;
      upLatch_reg <= 32'h00000000;
      lowLatch_reg <= 32'h00000000;
      pendingRead_reg <= 1'b0;
      pendingIdx_reg <= 6'd0;
      memRead <= 1'b0;
      memAddr <= {AW{1'b0}};
      resultWrite <= 1'b0;
      resultWord <= `RESULT_RESET;
      opDone <= 1'b0;
      opBusy <= 1'b0;
      errorFlag <= 1'b0;
      equalFlag <= 1'b0;
      greaterFlag <= 1'b0;
      lessFlag <= 1'b0;
      greaterOrEqualFlag <= 1'b0;
      lessOrEqualFlag <= 1'b0;
      notEqualFlag <= 1'b0;
      negativeFlag <= 1'b0;
    end else begin
      lastCond_reg <= inputCondition;
      memRead <= 1'b0;
      resultWrite <= 1'b0;
      opDone <= 1'b0;
      pendingRead_reg <= memRead;
      pendingIdx_reg <= issue_reg - 6'd1; // The read on the bus used the index before the step.
      case (state_reg)
        ST_IDLE: begin
          if (accept) begin
            opCode_reg <= opCode;
            source_reg <= sourceWord;
            base_reg <= baseAddr;
            lower_reg <= lowerAddr;
            upper_reg <= upperAddr;
            issue_reg <= 6'd0;
            count_reg <= 6'd0;
            mask_reg <= `RESULT_RESET;
            opBusy <= 1'b1;
            if (opCode == `OPC_TABLE_EQUAL) begin
              total_reg <= `TABLE_WORDS;
            end else if (opCode == `OPC_BLOCK_RANGE) begin
              total_reg <= `BLOCK_WORDS;
            end else if (opCode == `OPC_DOUBLE_RANGE) begin
              total_reg <= `DOUBLE_WORDS;
            end else begin
              total_reg <= `SINGLE_WORDS;
            end
            state_reg <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (issue_reg < total_reg) begin
            memRead <= 1'b1;
            memAddr <= fetchAddr(issue_reg);
            issue_reg <= issue_reg + 6'd1;
          end
          if (pendingRead_reg) begin
            count_reg <= count_reg + 6'd1;
            if (isTable) begin
              mask_reg[pendingIdx_reg[3:0]] <= (memReadData == source_reg);
            end else if (isBlock) begin
              if (!pendingIdx_reg[0]) begin
                lowWord_reg <= memReadData;
              end else begin
                mask_reg[pendingIdx_reg[4:1]] <= inRange({16'h0000, source_reg},
                  {16'h0000, lowWord_reg}, {16'h0000, memReadData});
              end
            end else if (isDouble) begin
              case (pendingIdx_reg[2:0])
                3'd1: valueHigh_reg <= memReadData;
                3'd2: lowLatch_reg[15:0] <= memReadData;
                3'd3: lowLatch_reg[31:16] <= memReadData;
                3'd4: lowWord_reg <= memReadData;
                3'd5: upLatch_reg <= {memReadData, lowWord_reg};
                default: begin
                end
              endcase
            end else begin
              case (pendingIdx_reg[1:0])
                2'd0: valueHigh_reg <= 16'h0000;
                2'd1: lowLatch_reg <= {16'h0000, memReadData};
                2'd2: upLatch_reg <= {16'h0000, memReadData};
                default: begin
                end
              endcase
            end
            if (count_reg + 6'd1 == total_reg) begin
              state_reg <= ST_LOAD;
            end
          end
        end
        ST_LOAD: begin
          if (isTable || isBlock) begin
            resultWrite <= 1'b1;
            resultWord <= mask_reg;
            equalFlag <= (mask_reg == 16'h0000);
            errorFlag <= 1'b0;
          end else begin
            // All operands are latched; the read bus no longer holds the last word here.
            greaterFlag <= valueWord > upLatch_reg;
            lessFlag <= valueWord < lowLatch_reg;
            equalFlag <= inRange(valueWord, lowLatch_reg, upLatch_reg);
            errorFlag <= lowLatch_reg > upLatch_reg;
            // Greater-or-equal, less-or-equal, not-equal and negative are untouched.
            greaterOrEqualFlag <= greaterOrEqualFlag;
          end
          state_reg <= ST_DONE;
        end
        ST_DONE: begin
          opDone <= 1'b1;
          opBusy <= 1'b0;
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // table_range_compare_unit

// ---- dv/table_range_compare_unit_properties.sv ----
// Checker for the compare datapath, bound to its top module.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`include "range_compare_map.vh"
module table_range_compare_unit_properties #(parameter AW = 16) (
  input wire ref_clk, input wire rst_b, input wire opStart, input wire [11:0] opCode,
  input wire inputCondition, input wire memRead, input wire [AW-1:0] memAddr,
  input wire resultWrite, input wire [15:0] resultWord, input wire opDone, input wire opBusy,
  input wire errorFlag, input wire equalFlag, input wire greaterFlag, input wire lessFlag,
  input wire greaterOrEqualFlag, input wire lessOrEqualFlag, input wire notEqualFlag,
  input wire negativeFlag
);
  reg [11:0] curOp_reg;
  reg [5:0] rdCnt_reg;
  wire isSingle = curOp_reg == `OPC_SINGLE_RANGE || curOp_reg == `OPC_DOUBLE_RANGE;
  wire [5:0] expReads = (curOp_reg == `OPC_TABLE_EQUAL) ? 6'd16 :
    (curOp_reg == `OPC_BLOCK_RANGE) ? 6'd32 : isSingle && curOp_reg[8] ? 6'd6 : 6'd3;
  // Remember the code of the request in flight and count its memory reads.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      curOp_reg <= 12'h000;
      rdCnt_reg <= 6'h00;
    end else begin
      if (opStart && !opBusy) curOp_reg <= opCode;
      rdCnt_reg <= opDone ? 6'h00 : rdCnt_reg + {5'h00, memRead};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence sDoneSoon; ##[1:40] opDone; endsequence
  sequence sNotTaken; ##1 !opBusy; endsequence
  AST_EQ_FROM_RESULT: assert property (
    resultWrite |-> equalFlag == (resultWord == 16'h0000) && !errorFlag)
    else $error("Equal flag disagrees with result word.");
  AST_DONE_AFTER_WRITE: assert property (resultWrite |=> opDone)
    else $error("Result write not followed by done.");
  AST_OTHER_FLAGS_FIXED: assert property (
    !(greaterOrEqualFlag || lessOrEqualFlag || notEqualFlag || negativeFlag))
    else $error("A flag that must stay unchanged moved.");
  AST_SINGLE_EXCL: assert property (
    opDone && isSingle |-> !(equalFlag && (greaterFlag || lessFlag)))
    else $error("Inside flag set together with outside flag.");
  AST_READ_COUNT: assert property (opDone |-> rdCnt_reg == expReads)
    else $error("Wrong number of operand reads.");
  AST_ADDR_SEQ: assert property (
    memRead && $past(memRead) && !isSingle |-> memAddr == $past(memAddr) + 1'b1)
    else $error("Operand reads not consecutive.");
  AST_DONE_BOUND: assert property ($rose(opBusy) |-> sDoneSoon)
    else $error("Operation did not complete in time.");
  AST_COND_GATE: assert property (
    opStart && !opBusy && !opDone && !inputCondition |-> sNotTaken)
    else $error("Request taken while condition low.");
endmodule // table_range_compare_unit_properties
bind table_range_compare_unit table_range_compare_unit_properties #(.AW(AW)) u_props (
  .ref_clk, .rst_b, .opStart, .opCode, .inputCondition, .memRead, .memAddr, .resultWrite,
  .resultWord, .opDone, .opBusy, .errorFlag, .equalFlag, .greaterFlag, .lessFlag,
  .greaterOrEqualFlag, .lessOrEqualFlag, .notEqualFlag, .negativeFlag);

// ---- dv/operand_memory_model.sv ----
// Data memory model answering the datapath's operand reads.
// Assumes the bench loads the word array directly between operations.
`timescale 1ns/1ps
module operand_memory_model #(parameter AW = 8) (
  input wire ref_clk,
  input wire memRead,
  input wire [AW-1:0] memAddr,
  output reg [15:0] memReadData
);
  reg [15:0] mem [0:(1<<AW)-1];
  initial memReadData = 16'h0000;
  // Data are valid one cycle after a read; otherwise the bus toggles so stale data never pass.
  always @(posedge ref_clk) begin
    memReadData <= memRead ? mem[memAddr] : ~memReadData;
  end
endmodule // operand_memory_model

// ---- dv/tb_top.sv ----
// Self-checking bench for the table, block and single-range compare datapath.
// Assumes the design, its constants header, the checker and the memory model are compiled.
`timescale 1ns/1ps
`include "range_compare_map.vh"
module tb_top;
  reg ref_clk = 1'b0, rst_b = 1'b0, opStart = 1'b0, opDifferentiated = 1'b0;
  reg inputCondition = 1'b0;
  reg [11:0] opCode = 12'h000;
  reg [15:0] sourceWord = 16'h0000, e, mask;
  reg [7:0] baseAddr = 8'h00, lowerAddr = 8'h00, upperAddr = 8'h00;
  wire memRead, resultWrite, opDone, opBusy;
  wire [7:0] memAddr, flags;
  wire [15:0] memReadData, resultWord;
  integer error_cnt = 0, compares = 0, i, k, n;
  reg [31:0] v, lo, hi, rnd;
  reg [1:0] gl;
  reg [11:0] codes [0:3];
  always #4 ref_clk = ~ref_clk;
  table_range_compare_unit #(.AW(8)) u_table_range_compare_unit (.ref_clk(ref_clk),
    .rst_b(rst_b), .opStart(opStart), .opCode(opCode), .opDifferentiated(opDifferentiated),
    .inputCondition(inputCondition), .sourceWord(sourceWord), .baseAddr(baseAddr),
    .lowerAddr(lowerAddr), .upperAddr(upperAddr), .memRead(memRead), .memAddr(memAddr),
    .memReadData(memReadData), .resultWrite(resultWrite), .resultWord(resultWord),
    .opDone(opDone), .opBusy(opBusy), .errorFlag(flags[7]), .equalFlag(flags[6]),
    .greaterFlag(flags[5]), .lessFlag(flags[4]), .greaterOrEqualFlag(flags[3]),
    .lessOrEqualFlag(flags[2]), .notEqualFlag(flags[1]), .negativeFlag(flags[0]));
  operand_memory_model #(.AW(8)) u_mem (.ref_clk(ref_clk), .memRead(memRead),
    .memAddr(memAddr), .memReadData(memReadData));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task finish_test;
    begin
      if (error_cnt == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  // Expected mask: equality per table word, or inclusive unsigned range per limit pair.
  function [15:0] maskExp(input [15:0] s, input [7:0] b, input blk);
    integer m;
    begin
      for (m = 0; m < 16; m = m + 1)
        maskExp[m] = blk ? (u_mem.mem[b+2*m] <= s && s <= u_mem.mem[b+2*m+1])
          : (u_mem.mem[b+m] == s);
    end
  endfunction
  // One operand value; the double form takes the higher address as upper half.
  function [31:0] w(input [7:0] a, input dbl);
    w = dbl ? {u_mem.mem[a+8'h01], u_mem.mem[a]} : {16'h0000, u_mem.mem[a]};
  endfunction
  // Issue one request on a rising condition and wait for completion.
  task run(input [11:0] op, input d);
    begin
      @(negedge ref_clk);
      inputCondition = 1'b0;
      @(negedge ref_clk);
      opCode = op;
      opDifferentiated = d;
      opStart = 1'b1;
      inputCondition = 1'b1;
      @(negedge ref_clk);
      opStart = 1'b0;
      n = 0;
      while (opDone !== 1'b1 && n < 50) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      if (n == 50) chk(16'h0001, 16'h0000);
    end
  endtask
  // Watchdog well beyond the expected run length.
  initial begin
    #160000;
    error_cnt = error_cnt + 1;
    $display("CHECK FAILED at %0t: timeout", $time);
    finish_test;
  end
  // Zero-filled corners first, then narrow and full-width random operands.
  initial begin
    codes[0] = `OPC_TABLE_EQUAL;
    codes[1] = `OPC_BLOCK_RANGE;
    codes[2] = `OPC_SINGLE_RANGE;
    codes[3] = `OPC_DOUBLE_RANGE;
    rnd = $urandom(35);
    repeat (12) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    for (i = 0; i < 40; i = i + 1) begin
      mask = (i < 8) ? 16'h0000 : (i < 32) ? 16'h0007 : 16'hffff;
      for (k = 0; k < 256; k = k + 1) begin
        rnd = $urandom;
        u_mem.mem[k] = rnd[15:0] & mask;
      end
      rnd = $urandom;
      sourceWord = (i < 8) ? {15'h0000, i[2]} : rnd[31:16] & mask;
      baseAddr = rnd[7:0] % 8'd200;
      lowerAddr = rnd[15:8] % 8'd200;
      upperAddr = rnd[23:16] % 8'd200;
      gl = flags[5:4];
      run(codes[i%4], i[2]);
      if (i % 4 < 2) begin
        e = maskExp(sourceWord, baseAddr, i % 4 == 1);
        chk(resultWord, e);
        chk({8'h00, flags}, {8'h00, 1'b0, e == 16'h0000, gl, 4'h0});
      end else begin
        v = w(baseAddr, i % 4 == 3);
        lo = w(lowerAddr, i % 4 == 3);
        hi = w(upperAddr, i % 4 == 3);
        e = {8'h00, lo > hi, lo <= v && v <= hi, v > hi, v < lo, 4'h0};
        chk({8'h00, flags}, e);
      end
    end
    opCode = `OPC_TABLE_EQUAL;
    opDifferentiated = 1'b0;
    inputCondition = 1'b0;
    opStart = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({15'h0000, opBusy}, 16'h0000);
    opStart = 1'b0;
    inputCondition = 1'b1;
    @(negedge ref_clk);
    opDifferentiated = 1'b1;
    opStart = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({15'h0000, opBusy}, 16'h0000);
    opCode = 12'h000;
    opDifferentiated = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({15'h0000, opBusy}, 16'h0000);
    opStart = 1'b0;
    finish_test;
  end
endmodule // tb_top
